/* rtl/phy_mgmt_pkg.sv */
// Package with register map, field positions and reset values of the control/status bank.
package phy_mgmt_pkg;

    localparam logic [4:0]  ADDR_CONTROL       = 5'h00;
    localparam logic [4:0]  ADDR_STATUS        = 5'h01;
    localparam logic [15:0] CONTROL_RESET      = 16'h3100;
    localparam logic [15:0] STATUS_RESET       = 16'h7849;
    localparam logic [15:0] CONTROL_WRITE_MASK = 16'hFF80;

    localparam int CTL_SOFT_RESET     = 15;
    localparam int CTL_LOOPBACK       = 14;
    localparam int CTL_SPEED_SELECT   = 13;
    localparam int CTL_AUTONEG_ENABLE = 12;
    localparam int CTL_POWER_DOWN     = 11;
    localparam int CTL_ISOLATE        = 10;
    localparam int CTL_AUTONEG_RESTART = 9;
    localparam int CTL_DUPLEX         = 8;
    localparam int CTL_COLLISION_TEST = 7;

    localparam int STS_AUTONEG_DONE   = 5;
    localparam int STS_REMOTE_FAULT   = 4;
    localparam int STS_LINK_VALID     = 2;
    localparam int STS_JABBER         = 1;

    // Cycles the soft reset is held before the self-clearing bit drops.
    localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;

    typedef struct packed {
        logic        read_strobe;
        logic        write_strobe;
        logic [4:0]  address;
        logic [15:0] write_data;
    } mgmt_request_type;

    typedef struct packed {
        logic        link_valid;
        logic        jabber;
        logic        remote_fault;
        logic        autoneg_done;
        logic        autoneg_duplex;
        logic        autoneg_duplex_valid;
        logic        tx_active;
    } phy_events_type;

    typedef struct packed {
        logic        soft_reset;
        logic        loopback;
        logic        speed_select;
        logic        autoneg_enable;
        logic        power_down;
        logic        isolate;
        logic        autoneg_restart;
        logic        full_duplex;
        logic        collision_test;
    } phy_mode_type;

endpackage

/* rtl/sync_levels.sv */
// Two-flop synchroniser for a group of level inputs from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sync_levels #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;

    always_comb begin
        state_next.first  = async_in;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;
endmodule
`default_nettype wire

/* rtl/phy_mgmt_control_status_regs.sv */
// Control and status register pair of the physical layer, reached over management access.
//
// Contract
// R1 - The control register resets to 0x3100: 100 Mb/s, auto-negotiation on, full duplex.
// R2 - Control bit 8 at one selects full duplex, set by software or by auto-negotiation.
// R3 - Control bit 8 at zero selects half duplex.
// R4 - Control bit 7 places the layer in collision test mode and resets to zero.
// R5 - The collision test bit sets once a transmission starts and clears when it halts.
// R6 - Software writes zeros into control bits 6:0.
// R7 - Software does not depend on reserved bits and preserves them in read-modify-write.
// R8 - The status register resets to 0x7849.
// R9 - The status register reports abilities and state; writes do not change it.
// R10 - Status bit 1 latches a jabber condition until the status register is read.
// R11 - Status bit 2 reads one while a valid link exists, zero otherwise.
// R12 - Status bit 0 always reads one.
// R13 - Writing one to control bit 15 restores defaults, then the bit clears itself.
// R14 - Writing one to control bit 9 restarts auto-negotiation, then the bit clears itself.
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_control_status_regs
    import phy_mgmt_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire mgmt_request_type mgmt_request,
    output logic [15:0]           read_data,
    output logic                  read_valid,
    input  wire phy_events_type   phy_events,
    output phy_mode_type          phy_mode,
    output logic                  autoneg_restart_pulse,
    output logic                  internal_reset
);
    typedef struct packed {
        logic [15:0] control;
        logic        jabber_latched;
        logic        fault_latched;
        logic [3:0]  soft_count;
        logic        tx_seen;
        logic [15:0] read_data;
        logic        read_valid;
        logic        restart_pulse;
    } regs_state_type;

    regs_state_type state_reg;
    regs_state_type state_next;
    phy_events_type events_sync;
    logic [15:0]    status_now;
    logic           write_control;
    logic           read_status;

    sync_levels #(
        .WIDTH($bits(phy_events_type))
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (phy_events),
        .sync_out (events_sync)
    );

    assign write_control = mgmt_request.write_strobe && mgmt_request.address == ADDR_CONTROL;
    assign read_status   = mgmt_request.read_strobe && mgmt_request.address == ADDR_STATUS;

    // Abilities are fixed; only state bits are live. Bit 0 comes from the reset constant.
    always_comb begin
        status_now                   = STATUS_RESET; // R8 R12
        status_now[STS_AUTONEG_DONE] = events_sync.autoneg_done;
        status_now[STS_REMOTE_FAULT] = state_reg.fault_latched;
        status_now[STS_LINK_VALID]   = events_sync.link_valid; // R11
        status_now[STS_JABBER]       = state_reg.jabber_latched; // R10
    end

    always_comb begin
        state_next               = state_reg;
        state_next.read_valid    = mgmt_request.read_strobe;
        state_next.restart_pulse = 1'b0;
        state_next.tx_seen       = events_sync.tx_active;
        if (mgmt_request.read_strobe) begin
            unique case (mgmt_request.address)
                ADDR_CONTROL: state_next.read_data = state_reg.control;
                ADDR_STATUS:  state_next.read_data = status_now;
                default:      state_next.read_data = 16'h0000;
            endcase
        end
        // Read-to-clear; a new event in the read cycle still sets, so set wins.
        if (read_status) begin
            state_next.jabber_latched = 1'b0; // R10
            state_next.fault_latched  = 1'b0;
        end
        if (events_sync.jabber) begin
            state_next.jabber_latched = 1'b1; // R10
        end
        if (events_sync.remote_fault) begin
            state_next.fault_latched = 1'b1;
        end
        // Status writes are dropped: below, only the soft reset touches status state.
        if (write_control) begin // R9
            state_next.control = mgmt_request.write_data & CONTROL_WRITE_MASK; // R6
        end
        if (events_sync.autoneg_duplex_valid && state_reg.control[CTL_AUTONEG_ENABLE]) begin
            state_next.control[CTL_DUPLEX] = events_sync.autoneg_duplex; // R2 R3
        end
        if (events_sync.tx_active && !state_reg.tx_seen) begin
            state_next.control[CTL_COLLISION_TEST] = 1'b1; // R5
        end else if (!events_sync.tx_active && state_reg.tx_seen) begin
            state_next.control[CTL_COLLISION_TEST] = 1'b0; // R5
        end
        if (state_reg.control[CTL_AUTONEG_RESTART]) begin
            state_next.restart_pulse                = 1'b1; // R14
            state_next.control[CTL_AUTONEG_RESTART] = 1'b0; // R14
        end
        // Soft reset holds internal state down for a few cycles, then restores defaults.
        if (state_reg.soft_count != 4'h0) begin
            state_next.soft_count = state_reg.soft_count - 4'h1;
            if (state_reg.soft_count == 4'h1) begin
                state_next.control        = CONTROL_RESET; // R13
                state_next.jabber_latched = 1'b0;
                state_next.fault_latched  = 1'b0;
            end
        end else if (state_reg.control[CTL_SOFT_RESET]) begin
            state_next.soft_count = SOFT_RESET_CYCLES; // R13
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg         <= '0;
            state_reg.control <= CONTROL_RESET; // R1
        end else begin
            state_reg <= state_next;
        end
    end

    assign read_data             = state_reg.read_data;
    assign read_valid            = state_reg.read_valid;
    assign autoneg_restart_pulse = state_reg.restart_pulse;
    assign internal_reset        = state_reg.soft_count != 4'h0;
    assign phy_mode.soft_reset      = state_reg.control[CTL_SOFT_RESET];
    assign phy_mode.loopback        = state_reg.control[CTL_LOOPBACK];
    assign phy_mode.speed_select    = state_reg.control[CTL_SPEED_SELECT];
    assign phy_mode.autoneg_enable  = state_reg.control[CTL_AUTONEG_ENABLE];
    assign phy_mode.power_down      = state_reg.control[CTL_POWER_DOWN];
    assign phy_mode.isolate         = state_reg.control[CTL_ISOLATE];
    assign phy_mode.autoneg_restart = state_reg.control[CTL_AUTONEG_RESTART];
    assign phy_mode.full_duplex     = state_reg.control[CTL_DUPLEX]; // R2 R3
    assign phy_mode.collision_test  = state_reg.control[CTL_COLLISION_TEST]; // R4

    a_control_reset_value: assert property (@(posedge clk) // R1
        !reset_n |=> state_reg.control == CONTROL_RESET)
        else $error("control register not at default after reset");
    a_duplex_from_autoneg: assert property (@(posedge clk) disable iff (!reset_n) // R2
        events_sync.autoneg_duplex_valid && state_reg.control[CTL_AUTONEG_ENABLE]
        && state_reg.soft_count != 4'h1
        |=> phy_mode.full_duplex == $past(events_sync.autoneg_duplex))
        else $error("duplex mode does not follow the negotiated result");
    a_half_duplex_write: assert property (@(posedge clk) disable iff (!reset_n) // R3
        write_control && !mgmt_request.write_data[CTL_DUPLEX]
        && !(events_sync.autoneg_duplex_valid && state_reg.control[CTL_AUTONEG_ENABLE])
        && state_reg.soft_count != 4'h1
        |=> !phy_mode.full_duplex)
        else $error("half duplex not selected after writing zero");
    a_collision_on_tx: assert property (@(posedge clk) disable iff (!reset_n) // R5
        events_sync.tx_active && !state_reg.tx_seen && state_reg.soft_count == 4'h0
        |=> phy_mode.collision_test)
        else $error("collision test bit not set at transmission start");
    a_status_reset_value: assert property (@(posedge clk) disable iff (!reset_n) // R8
        read_status && !events_sync.link_valid && !events_sync.autoneg_done
        && !state_reg.jabber_latched && !state_reg.fault_latched
        |=> read_data == STATUS_RESET)
        else $error("idle status reads differ from the default");
    a_jabber_holds: assert property (@(posedge clk) disable iff (!reset_n) // R10
        state_reg.jabber_latched && !read_status && state_reg.soft_count != 4'h1
        |=> state_reg.jabber_latched)
        else $error("jabber flag dropped without a status read");
    a_link_bit_live: assert property (@(posedge clk) disable iff (!reset_n) // R11
        read_status |=> read_data[2] == $past(events_sync.link_valid))
        else $error("link bit does not match link state");
    a_extended_one: assert property (@(posedge clk) disable iff (!reset_n) // R12
        read_status |=> read_data[0])
        else $error("extended capability bit reads zero");
    a_soft_reset_clears: assert property (@(posedge clk) disable iff (!reset_n) // R13
        state_reg.soft_count == 4'h0 && state_reg.control[15]
        |-> ##8 state_reg.soft_count == 4'h1 ##1 state_reg.control == CONTROL_RESET)
        else $error("soft reset did not restore defaults in time");
    a_restart_self_clear: assert property (@(posedge clk) disable iff (!reset_n) // R14
        state_reg.control[9] && state_reg.soft_count == 4'h0 && !write_control
        |=> autoneg_restart_pulse && !state_reg.control[9])
        else $error("restart bit not self-cleared with pulse");
    a_status_write_ignored: assert property (@(posedge clk) disable iff (!reset_n) // R9
        mgmt_request.write_strobe && mgmt_request.address == ADDR_STATUS
        && !events_sync.jabber && !read_status && state_reg.soft_count != 4'h1
        |=> state_reg.jabber_latched == $past(state_reg.jabber_latched))
        else $error("status write changed status state");

    c_jabber_read: cover property (@(posedge clk) state_reg.jabber_latched ##1 read_status);
    c_soft_reset: cover property (@(posedge clk) internal_reset ##1 !internal_reset);
    c_restart: cover property (@(posedge clk) autoneg_restart_pulse);
    c_collision: cover property (@(posedge clk) phy_mode.collision_test ##[1:20] !phy_mode.collision_test);
endmodule
`default_nettype wire

/* dv/mgmt_master.sv */
// Software-side management master that issues single-word reads and writes.
`timescale 1ns/1ps
`default_nettype none
module mgmt_master
    import phy_mgmt_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [15:0]      read_data,
    input  wire logic             read_valid,
    output mgmt_request_type      req
);
    initial req = '0;

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        mgmt_request_type r;
        r = '0;
        r.read_strobe = 1'b1;
        r.address = a;
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req <= '0;
        #1;
        d = (read_valid === 1'b1) ? read_data : 'x;
    endtask

    // Reserved control bits always leave as zero, whatever the caller passed.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_request_type r;
        r = '0;
        r.write_strobe = 1'b1;
        r.address = a;
        r.write_data = d & 16'hFF80;
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req <= '0;
        // Return just after the edge so that the caller sees the stored value.
        #1;
    endtask

    // Only the named bits change; bits 15:7 are written back as read, bits 6:0 as zero.
    task automatic rmw(input logic [4:0] a, input logic [15:0] set, input logic [15:0] clr);
        logic [15:0] d;
        rd(a, d);
        wr(a, (d & ~clr) | set);
    endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench of the control and status register pair.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    import phy_mgmt_pkg::*;
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    mgmt_request_type req;
    logic [15:0]      read_data;
    logic             read_valid;
    phy_events_type   ev = '0;
    phy_mode_type     phy_mode;
    logic             autoneg_restart_pulse;
    logic             internal_reset;
    int               errors = 0;
    int               check_count = 0;
    logic [15:0]      d;
    logic [4:0]       n;
    logic             seen;

    always #2.5 clk = ~clk;

    phy_mgmt_control_status_regs phy_mgmt_control_status_regs_inst (
        .clk                   (clk),
        .reset_n               (reset_n),
        .mgmt_request          (req),
        .read_data             (read_data),
        .read_valid            (read_valid),
        .phy_events            (ev),
        .phy_mode              (phy_mode),
        .autoneg_restart_pulse (autoneg_restart_pulse),
        .internal_reset        (internal_reset)
    );

    mgmt_master mgmt_master_inst (
        .clk        (clk),
        .read_data  (read_data),
        .read_valid (read_valid),
        .req        (req)
    );

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Events pass a two-flop synchroniser, so each change is given five cycles.
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        mgmt_master_inst.rd(5'h00, d);
        `CHK(d, 16'h3100)
        `CHK(phy_mode.full_duplex, 1'b1)
        `CHK(phy_mode.collision_test, 1'b0)
        `CHK(phy_mode, 9'h062)
        mgmt_master_inst.rd(5'h01, d);
        `CHK(d, 16'h7849)
        `CHK(d[0], 1'b1)
        mgmt_master_inst.rmw(5'h00, 16'h0000, 16'h1100);
        mgmt_master_inst.rd(5'h00, d);
        `CHK(d, 16'h2000)
        `CHK(phy_mode.full_duplex, 1'b0)
        mgmt_master_inst.rmw(5'h00, 16'h0100, 16'h0000);
        `CHK(phy_mode.full_duplex, 1'b1)
        mgmt_master_inst.wr(5'h01, 16'h0000);
        mgmt_master_inst.rd(5'h01, d);
        `CHK(d, 16'h7849)
        mgmt_master_inst.rd(5'h1F, d);
        `CHK(d, 16'h0000)
        @(posedge clk);
        ev.link_valid <= 1'b1;
        settle();
        mgmt_master_inst.rd(5'h01, d);
        `CHK(d, 16'h784D)
        @(posedge clk);
        ev.link_valid <= 1'b0;
        ev.jabber <= 1'b1;
        repeat (3) @(posedge clk);
        ev.jabber <= 1'b0;
        settle();
        mgmt_master_inst.rd(5'h01, d);
        `CHK(d, 16'h784B)
        mgmt_master_inst.rd(5'h01, d);
        `CHK(d, 16'h7849)
        @(posedge clk);
        ev.remote_fault <= 1'b1;
        ev.autoneg_done <= 1'b1;
        settle();
        ev.remote_fault <= 1'b0;
        settle();
        mgmt_master_inst.rd(5'h01, d);
        `CHK(d, 16'h7879)
        mgmt_master_inst.rd(5'h01, d);
        `CHK(d, 16'h7869)
        @(posedge clk);
        ev.autoneg_done <= 1'b0;
        ev.tx_active <= 1'b1;
        settle();
        mgmt_master_inst.rd(5'h00, d);
        `CHK(d, 16'h2180)
        `CHK(phy_mode.collision_test, 1'b1)
        @(posedge clk);
        ev.tx_active <= 1'b0;
        settle();
        mgmt_master_inst.rd(5'h00, d);
        `CHK(d, 16'h2100)
        mgmt_master_inst.wr(5'h00, 16'h3300);
        seen = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1;
            if (autoneg_restart_pulse === 1'b1)
                seen = 1'b1;
        end
        `CHK(seen, 1'b1)
        mgmt_master_inst.rd(5'h00, d);
        `CHK(d, 16'h3100)
        @(posedge clk);
        ev.autoneg_duplex_valid <= 1'b1;
        settle();
        `CHK(phy_mode.full_duplex, 1'b0)
        ev.autoneg_duplex <= 1'b1;
        settle();
        `CHK(phy_mode.full_duplex, 1'b1)
        mgmt_master_inst.rd(5'h00, d);
        `CHK(d, 16'h3100)
        ev.autoneg_duplex_valid <= 1'b0;
        ev.autoneg_duplex <= 1'b0;
        settle();
        mgmt_master_inst.wr(5'h00, 16'h0000);
        mgmt_master_inst.wr(5'h00, 16'h8000);
        n = '0;
        repeat (20) begin
            @(posedge clk);
            #1;
            if (internal_reset === 1'b1)
                n++;
        end
        `CHK(n, {1'b0, SOFT_RESET_CYCLES})
        mgmt_master_inst.rd(5'h00, d);
        `CHK(d, 16'h3100)
        `CHK(phy_mode.soft_reset, 1'b0)
        summarize();
    end

    // The sequence needs under two hundred cycles; this bound leaves ample margin.
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
